// ### src/bbou_pkg.sv
// ----------------------------------------------------------------
// branch and bit operations unit: shared constants and types
// ----------------------------------------------------------------
package bbou_pkg;

    // ------------------------------------------------------------
    // bus geometry and register byte offsets
    // ------------------------------------------------------------
    localparam int unsigned ADR_W     = 8;
    localparam int unsigned DAT_W     = 32;
    localparam int unsigned IO_N      = 8;
    localparam logic [7:0]  OFS_CMD   = 8'h00;
    localparam logic [7:0]  OFS_FLAGS = 8'h04;
    localparam logic [7:0]  OFS_WREG  = 8'h08;
    localparam logic [7:0]  OFS_PC    = 8'h0c;
    localparam logic [7:0]  OFS_STAT  = 8'h10;
    // io window: 8 words from this base, selected by address bits 4:2
    localparam logic [2:0]  IO_WIN    = 3'h1;

    // ------------------------------------------------------------
    // command word fields (lsb positions)
    // ------------------------------------------------------------
    localparam int unsigned CMD_OP_LSB  = 0;
    localparam int unsigned CMD_BIT_LSB = 8;
    localparam int unsigned CMD_IOA_LSB = 12;
    localparam int unsigned CMD_OFS_LSB = 16;

    // ------------------------------------------------------------
    // status_flag_register bit positions
    // ------------------------------------------------------------
    localparam logic [2:0] FLG_C = 3'h0;
    localparam logic [2:0] FLG_Z = 3'h1;
    localparam logic [2:0] FLG_N = 3'h2;
    localparam logic [2:0] FLG_V = 3'h3;
    localparam logic [2:0] FLG_S = 3'h4;
    localparam logic [2:0] FLG_H = 3'h5;
    localparam logic [2:0] FLG_T = 3'h6;
    localparam logic [2:0] FLG_I = 3'h7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] PC_RST    = 16'h0000;
    localparam logic [7:0]  FLAGS_RST = 8'h00;
    localparam logic [7:0]  WREG_RST  = 8'h00;
    localparam logic [31:0] CMD_RST   = 32'h0000_0000;

    // ------------------------------------------------------------
    // operations and sequencer states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NOP      = 5'h00,
        OP_BR_SET   = 5'h01,
        OP_BR_CLR   = 5'h02,
        OP_BR_GE    = 5'h03,
        OP_BR_LT    = 5'h04,
        OP_IO_SET   = 5'h05,
        OP_IO_CLR   = 5'h06,
        OP_LSL      = 5'h07,
        OP_LSR      = 5'h08,
        OP_ROL      = 5'h09,
        OP_ROR      = 5'h0a,
        OP_ASR      = 5'h0b,
        OP_FLAG_SET = 5'h0c,
        OP_FLAG_CLR = 5'h0d,
        OP_BST      = 5'h0e,
        OP_BLD      = 5'h0f,
        OP_INT_ON   = 5'h10,
        OP_INT_OFF  = 5'h11
    } bbou_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_WAIT = 3'b100
    } bbou_state_t;

    typedef struct packed {
        bbou_state_t           state;
        logic [15:0]           pc;
        logic [7:0]            flags;
        logic [7:0]            wreg;
        logic [IO_N-1:0][7:0]  io;
        logic [31:0]           cmd;
        logic                  ack;
        logic [31:0]           rdat;
        logic                  taken;
    } bbou_regs_t;

endpackage : bbou_pkg

// ### src/bbou_shift.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// shift and rotate datapath
// ----------------------------------------------------------------
module bbou_shift (
    input  wire bbou_pkg::bbou_op_t op_i,
    input  wire logic [7:0]         val_i,
    input  wire logic               carry_i,
    output logic [7:0]              res_o,
    output logic                    carry_o
);
    import bbou_pkg::*;

    // one bit shift per op, carry is the bit pushed out
    always_comb begin
        res_o   = val_i;
        carry_o = carry_i;
        case (op_i)
            OP_LSL: begin
                res_o   = {val_i[6:0], 1'b0};
                carry_o = val_i[7];
            end
            OP_LSR: begin
                res_o   = {1'b0, val_i[7:1]};
                carry_o = val_i[0];
            end
            OP_ROL: begin
                res_o   = {val_i[6:0], carry_i};
                carry_o = val_i[7];
            end
            OP_ROR: begin
                res_o   = {carry_i, val_i[7:1]};
                carry_o = val_i[0];
            end
            OP_ASR: begin
                res_o   = {val_i[7], val_i[7:1]};  // sign bit stays put
                carry_o = val_i[0];
            end
            default: begin
                res_o   = val_i;
                carry_o = carry_i;
            end
        endcase
    end

endmodule : bbou_shift

// ### src/bbou_unit.sv
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
module bbou_unit (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      ce_i,
    input  wire logic                      cyc_i,
    input  wire logic                      stb_i,
    input  wire logic                      we_i,
    input  wire logic [bbou_pkg::ADR_W-1:0] adr_i,
    input  wire logic [3:0]                sel_i,
    input  wire logic [bbou_pkg::DAT_W-1:0] dat_i,
    output logic      [bbou_pkg::DAT_W-1:0] dat_o,
    output logic                           ack_o,
    output logic                           busy_o
);
    import bbou_pkg::*;

    // ------------------------------------------------------------
    // state, reset value, decoded command
    // ------------------------------------------------------------
    localparam bbou_regs_t REGS_RST = '{
        state: ST_IDLE,
        pc:    PC_RST,
        flags: FLAGS_RST,
        wreg:  WREG_RST,
        io:    '0,
        cmd:   CMD_RST,
        ack:   1'b0,
        rdat:  32'h0000_0000,
        taken: 1'b0
    };

    bbou_regs_t  st_q;
    bbou_regs_t  st_d;
    bbou_op_t    op;
    logic [2:0]  bidx;
    logic [2:0]  ioa;
    logic [6:0]  offs;
    logic        take;
    logic [15:0] br_target;
    logic [15:0] pc_next;
    logic [7:0]  sh_res;
    logic        sh_carry;
    logic        req;
    logic        acc_ok;
    logic        is_branch;

    // command fields are held in the command register during execution
    assign op   = bbou_op_t'(st_q.cmd[CMD_OP_LSB +: 5]);
    assign bidx = st_q.cmd[CMD_BIT_LSB +: 3];
    assign ioa  = st_q.cmd[CMD_IOA_LSB +: 3];
    assign offs = st_q.cmd[CMD_OFS_LSB +: 7];

    // ------------------------------------------------------------
    // branch condition and target
    // ------------------------------------------------------------
    // one index-driven test covers every single-flag branch form
    always_comb begin
        is_branch = 1'b0;
        take      = 1'b0;
        case (op)
            OP_BR_SET: begin
                is_branch = 1'b1;
                take      = st_q.flags[bidx];
            end
            OP_BR_CLR: begin
                is_branch = 1'b1;
                take      = ~st_q.flags[bidx];
            end
            OP_BR_GE: begin
                is_branch = 1'b1;
                take      = ~(st_q.flags[FLG_N] ^ st_q.flags[FLG_V]);
            end
            OP_BR_LT: begin
                is_branch = 1'b1;
                take      = st_q.flags[FLG_N] ^ st_q.flags[FLG_V];
            end
            default: begin
                is_branch = 1'b0;
                take      = 1'b0;
            end
        endcase
    end

    // sign-extended word displacement added to the incremented counter
    assign pc_next   = st_q.pc + 16'h0001;
    assign br_target = pc_next + {{9{offs[6]}}, offs};

    // ------------------------------------------------------------
    // shifter
    // ------------------------------------------------------------
    bbou_shift u_shift (
        .op_i    (op),
        .val_i   (st_q.wreg),
        .carry_i (st_q.flags[FLG_C]),
        .res_o   (sh_res),
        .carry_o (sh_carry)
    );

    // ------------------------------------------------------------
    // next state: bus slave and sequencer
    // ------------------------------------------------------------
    // bus answers only while idle, so software never races execution
    assign req    = cyc_i & stb_i;
    assign acc_ok = req & ~st_q.ack & (st_q.state == ST_IDLE);

    always_comb begin
        st_d     = st_q;
        st_d.ack = acc_ok;
        // read data is captured with the ack so it stands for that edge
        if (acc_ok) begin
            case (adr_i)
                OFS_CMD:   st_d.rdat = st_q.cmd;
                OFS_FLAGS: st_d.rdat = {24'h000000, st_q.flags};
                OFS_WREG:  st_d.rdat = {24'h000000, st_q.wreg};
                OFS_PC:    st_d.rdat = {16'h0000, st_q.pc};
                OFS_STAT:  st_d.rdat = {30'h0000_0000, st_q.taken, 1'b0};
                default: begin
                    if (adr_i[7:5] == IO_WIN && adr_i[1:0] == 2'b00) begin
                        st_d.rdat = {24'h000000, st_q.io[adr_i[4:2]]};
                    end else begin
                        st_d.rdat = 32'h0000_0000;
                    end
                end
            endcase
        end
        // writes take effect on the edge where ack is seen high
        if (st_q.ack & req & we_i) begin
            case (adr_i)
                OFS_CMD: begin
                    for (int k = 0; k < 4; k++) begin
                        if (sel_i[k]) begin
                            st_d.cmd[k*8 +: 8] = dat_i[k*8 +: 8];
                        end
                    end
                    st_d.state = ST_EXEC;
                end
                OFS_FLAGS: begin
                    if (sel_i[0]) begin
                        st_d.flags = dat_i[7:0];
                    end
                end
                OFS_WREG: begin
                    if (sel_i[0]) begin
                        st_d.wreg = dat_i[7:0];
                    end
                end
                OFS_PC: begin
                    if (sel_i[0]) begin
                        st_d.pc[7:0] = dat_i[7:0];
                    end
                    if (sel_i[1]) begin
                        st_d.pc[15:8] = dat_i[15:8];
                    end
                end
                default: begin
                    if (adr_i[7:5] == IO_WIN && adr_i[1:0] == 2'b00 && sel_i[0]) begin
                        st_d.io[adr_i[4:2]] = dat_i[7:0];
                    end
                end
            endcase
        end
        // sequencer: one cycle for most ops, a wait cycle for long ones
        case (st_q.state)
            ST_IDLE: begin
            end
            ST_EXEC: begin
                st_d.state = ST_IDLE;
                st_d.pc    = pc_next;
                st_d.taken = 1'b0;
                case (op)
                    OP_BR_SET, OP_BR_CLR, OP_BR_GE, OP_BR_LT: begin
                        // branches leave every flag alone
                        if (take) begin
                            st_d.pc    = br_target;
                            st_d.taken = 1'b1;
                            st_d.state = ST_WAIT;
                        end
                    end
                    OP_IO_SET: begin
                        st_d.io[ioa][bidx] = 1'b1;
                        st_d.state         = ST_WAIT;
                    end
                    OP_IO_CLR: begin
                        st_d.io[ioa][bidx] = 1'b0;
                        st_d.state         = ST_WAIT;
                    end
                    OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR: begin
                        st_d.wreg         = sh_res;
                        st_d.flags[FLG_C] = sh_carry;
                        st_d.flags[FLG_Z] = (sh_res == 8'h00);
                        st_d.flags[FLG_N] = sh_res[7];
                        st_d.flags[FLG_V] = sh_res[7] ^ sh_carry;
                    end
                    OP_FLAG_SET: begin
                        st_d.flags[bidx] = 1'b1;
                    end
                    OP_FLAG_CLR: begin
                        st_d.flags[bidx] = 1'b0;
                    end
                    OP_BST: begin
                        st_d.flags[FLG_T] = st_q.wreg[bidx];
                    end
                    OP_BLD: begin
                        st_d.wreg[bidx] = st_q.flags[FLG_T];
                    end
                    OP_INT_ON: begin
                        st_d.flags[FLG_I] = 1'b1;
                    end
                    OP_INT_OFF: begin
                        st_d.flags[FLG_I] = 1'b0;
                    end
                    default: begin
                        // unknown codes only step the counter and clear taken
                    end
                endcase
            end
            ST_WAIT: begin
                st_d.state = ST_IDLE;
            end
            default: begin
                st_d.state = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // clock enable low freezes everything, the bus included
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= REGS_RST;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end

    // ack is masked while frozen: a master seeing it then would lose its write
    assign dat_o  = st_q.rdat;
    assign ack_o  = st_q.ack & ce_i;
    assign busy_o = (st_q.state != ST_IDLE);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    ne_cond_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q.state == ST_EXEC && op == OP_BR_CLR && bidx == FLG_Z)
            |-> (take == ~st_q.flags[FLG_Z]))
        else $error("zero clear branch condition wrong");

    br_taken_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q.state == ST_EXEC && ce_i && is_branch && take)
            |=> (st_q.state == ST_WAIT && st_q.pc == $past(st_q.pc) + 16'h0001
                 + {{9{$past(offs[6])}}, $past(offs)} && $past(st_q.flags) == st_q.flags))
        else $error("taken branch target or length wrong");

    br_fall_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q.state == ST_EXEC && ce_i && is_branch && !take)
            |=> (st_q.state == ST_IDLE && st_q.pc == $past(st_q.pc) + 16'h0001
                 && $past(st_q.flags) == st_q.flags))
        else $error("untaken branch not one cycle");

    ge_cond_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q.state == ST_EXEC && op == OP_BR_GE)
            |-> (take == (st_q.flags[FLG_N] == st_q.flags[FLG_V])))
        else $error("signed ge condition wrong");

    lt_cond_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q.state == ST_EXEC && op == OP_BR_LT)
            |-> (take == (st_q.flags[FLG_N] != st_q.flags[FLG_V])))
        else $error("signed lt condition wrong");

    io_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q.state == ST_EXEC && ce_i && (op == OP_IO_SET || op == OP_IO_CLR))
            |=> (st_q.state == ST_WAIT && $past(st_q.flags) == st_q.flags
                 && st_q.io[$past(ioa)][$past(bidx)] == ($past(op) == OP_IO_SET)))
        else $error("io bit op wrong");

    lsl_res_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q.state == ST_EXEC && ce_i && op == OP_LSL)
            |=> (st_q.wreg == {$past(st_q.wreg[6:0]), 1'b0}
                 && st_q.flags[FLG_C] == $past(st_q.wreg[7]) && st_q.state == ST_IDLE))
        else $error("left shift wrong");

    asr_res_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q.state == ST_EXEC && ce_i && op == OP_ASR)
            |=> (st_q.wreg[7] == $past(st_q.wreg[7]) && st_q.wreg[6:0] == $past(st_q.wreg[7:1])
                 && st_q.flags[FLG_C] == $past(st_q.wreg[0])))
        else $error("arithmetic shift wrong");

    bst_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q.state == ST_EXEC && ce_i && op == OP_BST)
            |=> (st_q.flags[FLG_T] == $past(st_q.wreg[bidx])
                 && st_q.flags[5:0] == $past(st_q.flags[5:0])
                 && st_q.flags[FLG_I] == $past(st_q.flags[FLG_I])))
        else $error("bit store to transfer flag wrong");

    int_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q.state == ST_EXEC && ce_i && (op == OP_INT_ON || op == OP_INT_OFF))
            |=> (st_q.flags[FLG_I] == ($past(op) == OP_INT_ON) && st_q.state == ST_IDLE))
        else $error("interrupt enable op wrong");

    // a frozen unit must neither answer the bus nor move
    ce_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ce_i |-> (!ack_o ##1 (st_q == $past(st_q))))
        else $error("clock enable low did not freeze the unit");

    rol_res_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q.state == ST_EXEC && ce_i && op == OP_ROL)
            |=> (st_q.wreg == {$past(st_q.wreg[6:0]), $past(st_q.flags[FLG_C])}
                 && st_q.flags[FLG_C] == $past(st_q.wreg[7])))
        else $error("rotate left through carry wrong");

    ror_res_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q.state == ST_EXEC && ce_i && op == OP_ROR)
            |=> (st_q.wreg == {$past(st_q.flags[FLG_C]), $past(st_q.wreg[7:1])}
                 && st_q.flags[FLG_C] == $past(st_q.wreg[0]) && st_q.state == ST_IDLE))
        else $error("rotate right through carry wrong");

    flag_idx_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q.state == ST_EXEC && ce_i && (op == OP_FLAG_SET || op == OP_FLAG_CLR))
            |=> (st_q.flags[$past(bidx)] == ($past(op) == OP_FLAG_SET)
                 && st_q.state == ST_IDLE))
        else $error("indexed flag set or clear wrong");

    bld_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q.state == ST_EXEC && ce_i && op == OP_BLD)
            |=> (st_q.wreg[$past(bidx)] == $past(st_q.flags[FLG_T])
                 && st_q.flags == $past(st_q.flags)))
        else $error("bit load from transfer flag wrong");

endmodule : bbou_unit

// ### verif/test_branch_and_bit_ops_unit.sv
`timescale 1ns/1ps
module test_branch_and_bit_ops_unit;
    import bbou_pkg::*;

    // ------------------------------------------------------------
    // signals and bench state
    // ------------------------------------------------------------
    logic        clk_i;
    logic        rst_i;
    logic        ce_i;
    logic        cyc_i;
    logic        stb_i;
    logic        we_i;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        busy_o;
    int          fail_count;
    int          compares;
    int          cyc_n;
    logic [31:0] rv;
    logic [15:0] pcx;
    logic [7:0]  f;
    logic [7:0]  sv;
    logic [7:0]  r;
    logic [7:0]  ef;
    logic [6:0]  k;
    logic        c;
    logic        tk;
    logic [7:0]  vals [3];

    bbou_unit u_dut (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .cyc_i  (cyc_i),
        .stb_i  (stb_i),
        .we_i   (we_i),
        .adr_i  (adr_i),
        .sel_i  (sel_i),
        .dat_i  (dat_i),
        .dat_o  (dat_o),
        .ack_o  (ack_o),
        .busy_o (busy_o)
    );

    // 25 ns period; hang guard far above the roughly 1700 cycles needed
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            fail_count++;
            $display("BAD timeout expected %0d seen %0d", 0, cyc_n);
            test_done();
        end
    end

    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // classic cycle: held until ack sampled high, released at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0000_0000, q);
        chk(nm, e, q);
    endtask : rd_chk

    task automatic setup(input logic [7:0] fl, input logic [7:0] w, input logic [15:0] p);
        wr(OFS_FLAGS, {24'h00_0000, fl});
        wr(OFS_WREG, {24'h00_0000, w});
        wr(OFS_PC, {16'h0000, p});
    endtask : setup

    // issue a command and count the cycles busy_o stays up
    task automatic exec(input logic [4:0] op, input logic [2:0] b, input logic [2:0] io,
                        input logic [6:0] ofs, input int nexp);
        int n;
        n = 0;
        wr(OFS_CMD, {9'h000, ofs, 1'b0, io, 1'b0, b, 3'h0, op});
        #1;
        while (busy_o === 1'b1 && n < 8) begin
            n++;
            @(posedge clk_i);
            #1;
        end
        chk("busy cycles", nexp, n);
    endtask : exec

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        ce_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 8'h00;
        sel_i = 4'hf;
        dat_i = 32'h0000_0000;
        fail_count = 0;
        compares = 0;
        cyc_n = 0;
        vals = '{8'h81, 8'h00, 8'h40};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values, unmapped read and ignored unmapped write
        rd_chk("cmd", OFS_CMD, 32'h0000_0000);
        rd_chk("flags", OFS_FLAGS, 32'h0000_0000);
        rd_chk("wreg", OFS_WREG, 32'h0000_0000);
        rd_chk("pc", OFS_PC, 32'h0000_0000);
        wr(8'h44, 32'h0000_00ff);
        rd_chk("unmapped", 8'h44, 32'h0000_0000);
        // single-flag branches, every index, both polarities, offset extremes
        for (int i = 0; i < 8; i++) for (int v = 0; v < 2; v++) for (int o = 1; o < 3; o++) begin
            k  = (i % 2) ? 7'h40 : 7'h3f;
            f  = v ? (8'h01 << i) : ~(8'h01 << i);
            tk = ((o == 1) == (v == 1));
            setup(f, 8'h00, 16'h0100);
            exec(o[4:0], i[2:0], 3'h0, k, tk ? 2 : 1);
            pcx = tk ? 16'h0101 + {{9{k[6]}}, k} : 16'h0101;
            rd_chk("branch pc", OFS_PC, {16'h0000, pcx});
            rd_chk("branch flags", OFS_FLAGS, {24'h00_0000, f});
            wb(1'b0, OFS_STAT, 32'h0000_0000, rv);
            chk("branch taken", {31'h0, tk}, {31'h0, rv[1]});
        end
        // signed compare branches over all N and V combinations
        for (int n = 0; n < 2; n++) for (int v = 0; v < 2; v++) for (int o = 3; o < 5; o++) begin
            f  = (v[7:0] << 3) | (n[7:0] << 2);
            tk = (o == 3) ? ((n ^ v) == 0) : ((n ^ v) == 1);
            setup(f, 8'h00, 16'h0100);
            exec(o[4:0], 3'h0, 3'h0, 7'h7d, tk ? 2 : 1);
            rd_chk("signed pc", OFS_PC, tk ? 32'h0000_00fe : 32'h0000_0101);
        end
        // io bit set and clear, flags left alone
        setup(8'ha5, 8'h00, 16'h0000);
        wr(8'h2c, 32'h0000_005a);
        exec(OP_IO_SET, 3'h0, 3'h3, 7'h00, 2);
        rd_chk("io set", 8'h2c, 32'h0000_005b);
        exec(OP_IO_CLR, 3'h6, 3'h3, 7'h00, 2);
        rd_chk("io clr", 8'h2c, 32'h0000_001b);
        exec(OP_IO_SET, 3'h7, 3'h3, 7'h00, 2);
        rd_chk("io set7", 8'h2c, 32'h0000_009b);
        rd_chk("io flags", OFS_FLAGS, 32'h0000_00a5);
        rd_chk("io other", 8'h28, 32'h0000_0000);
        // shifts and rotates; flags S, H and T set to catch stray writes
        for (int o = 7; o < 12; o++) for (int j = 0; j < 3; j++) begin
            sv = vals[j];
            c  = (o + j) % 2;
            case (o)
                7: begin r = {sv[6:0], 1'b0}; ef[0] = sv[7]; end
                8: begin r = {1'b0, sv[7:1]}; ef[0] = sv[0]; end
                9: begin r = {sv[6:0], c}; ef[0] = sv[7]; end
                10: begin r = {c, sv[7:1]}; ef[0] = sv[0]; end
                default: begin r = {sv[7], sv[7:1]}; ef[0] = sv[0]; end
            endcase
            ef[7:1] = {4'h7, r[7] ^ ef[0], r[7], r == 8'h00};
            setup(8'h70 | {7'h00, c}, sv, 16'h0010);
            exec(o[4:0], 3'h0, 3'h0, 7'h00, 1);
            rd_chk("shift res", OFS_WREG, {24'h00_0000, r});
            rd_chk("shift flags", OFS_FLAGS, {24'h00_0000, ef});
        end
        // per-index flag set/clear, bit store and bit load
        for (int i = 0; i < 8; i++) begin
            setup(8'h00, 8'h24, 16'h0000);
            exec(OP_FLAG_SET, i[2:0], 3'h0, 7'h00, 1);
            rd_chk("flag set", OFS_FLAGS, {24'h00_0000, 8'h01 << i});
            exec(OP_BST, i[2:0], 3'h0, 7'h00, 1);
            f = (8'h01 << i) | (8'h24 >> i & 8'h01) << 6;
            f = (i == 6) ? 8'h00 : f;
            rd_chk("bit store", OFS_FLAGS, {24'h00_0000, f});
            setup(8'hff, 8'h5a, 16'h0000);
            exec(OP_FLAG_CLR, i[2:0], 3'h0, 7'h00, 1);
            f = ~(8'h01 << i);
            rd_chk("flag clr", OFS_FLAGS, {24'h00_0000, f});
            exec(OP_BLD, i[2:0], 3'h0, 7'h00, 1);
            sv = 8'h5a;
            sv[i] = f[6];
            rd_chk("bit load", OFS_WREG, {24'h00_0000, sv});
            rd_chk("bit load flags", OFS_FLAGS, {24'h00_0000, f});
        end
        // interrupt enable and disable, plus plain advance
        setup(8'h00, 8'h00, 16'h0020);
        exec(OP_INT_ON, 3'h0, 3'h0, 7'h00, 1);
        rd_chk("int on", OFS_FLAGS, 32'h0000_0080);
        wr(OFS_FLAGS, 32'h0000_00ff);
        exec(OP_INT_OFF, 3'h0, 3'h0, 7'h00, 1);
        rd_chk("int off", OFS_FLAGS, 32'h0000_007f);
        exec(OP_NOP, 3'h0, 3'h0, 7'h00, 1);
        rd_chk("nop pc", OFS_PC, 32'h0000_0023);
        // clock enable low holds an instruction in flight
        setup(8'h00, 8'h00, 16'h0030);
        wr(OFS_CMD, {27'h0, OP_INT_ON});
        ce_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("frozen busy", 32'h0000_0001, {31'h0, busy_o});
        ce_i <= 1'b1;
        rd_chk("frozen int", OFS_FLAGS, 32'h0000_0080);
        rd_chk("frozen pc", OFS_PC, 32'h0000_0031);
        // enable drops right after the answer is registered: write must still land
        fork
            wr(OFS_WREG, 32'h0000_00c3);
            begin
                repeat (2) @(posedge clk_i);
                ce_i <= 1'b0;
                repeat (2) @(posedge clk_i);
                ce_i <= 1'b1;
            end
        join
        rd_chk("frozen write", OFS_WREG, 32'h0000_00c3);
        test_done();
    end
endmodule : test_branch_and_bit_ops_unit
